// ### core/power_wake_pkg.sv
package power_wake_pkg;

	// Clock and timing figures
	localparam int unsigned     CLK_PERIOD_NS = 4;
	localparam longint unsigned NS_PER_S      = 64'h0000_0000_3B9A_CA00;
	localparam longint unsigned NS_PER_MS     = 64'h0000_0000_000F_4240;
	localparam longint unsigned LONG_PRESS_S  = 4;
	localparam longint unsigned DEBOUNCE_MS   = 20;
	localparam longint unsigned LONG_PRESS_CYC = LONG_PRESS_S * NS_PER_S / CLK_PERIOD_NS;
	localparam longint unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int              CNT_W          = 32;

	// System power states, one-hot
	typedef enum logic [4:0] {
		WORKING  = 5'h01,
		SLEEP_S1 = 5'h02,
		SLEEP_S3 = 5'h04,
		SLEEP_S4 = 5'h08,
		SOFT_OFF = 5'h10
	} power_state_type;

	// Sleep state entered by a short press while working
	localparam power_state_type SHORT_PRESS_SLEEP = SLEEP_S3;

	// Wake request levels, active high
	typedef struct packed {
		logic lan;
		logic pme;
		logic pcieWake;
		logic ps2;
		logic rtc;
		logic serial;
		logic usb;
	} wake_src_type;

	// Operating-system state request
	typedef struct packed {
		logic            valid;
		power_state_type target;
	} os_req_type;

	// Outputs of the controller
	typedef struct packed {
		power_state_type state;
		logic            mainPowerOn;
		logic            cpuRunning;
		logic            wakeLogicOn;
		logic            stateChanged;
	} power_status_type;

	// Whole controller state
	typedef struct packed {
		power_status_type status;
		logic             swLevel;
		logic [CNT_W-1:0] swCnt;
		logic [CNT_W-1:0] holdCnt;
		logic             longDone;
		logic             s5WakeEn;
		logic             ready;
	} ctrl_type;

	localparam power_status_type STATUS_RESET = '{
		state: SOFT_OFF, mainPowerOn: 1'b0, cpuRunning: 1'b0,
		wakeLogicOn: 1'b1, stateChanged: 1'b0};

	localparam ctrl_type CTRL_RESET = '{
		status: STATUS_RESET, swLevel: 1'b0, swCnt: '0, holdCnt: '0,
		longDone: 1'b0, s5WakeEn: 1'b0, ready: 1'b0};

endpackage

// ### core/system_power_wake_control.sv
`timescale 1ns/1ps

// How it works
// [R1] Short press: off to working, working to sleep, sleep back to working.
// [R2] Press held four seconds or more forces soft-off from working or sleep.
// [R3] Next state depends on both current state and press length.
// [R4] Other transitions only happen on an operating-system request.
// [R5] In S3, S4 and S5 only wake logic stays powered; processor unpowered.
// [R6] LAN and PME wake the system from S1, S3 and S4.
// [R7] LAN or PME wake from S5 needs an enable that resets off.
// [R8] Each wake source is accepted only in its listed sleep states.
// [R9] Wake from S3 returns to the working state held before sleep.
// [R10] After mains returns, resume prior on or off state if configured.
// [R11] Switch debounced and timed by counter; exactly four seconds counts long.
module system_power_wake_control
	import power_wake_pkg::*;
#(
	parameter logic [CNT_W-1:0] LONG_PRESS_CYCLES = CNT_W'(LONG_PRESS_CYC),
	parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES   = CNT_W'(DEBOUNCE_CYC)
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// Front-panel switch, high while pressed
	input  wire logic             pwrSwitch,
	// Wake sources
	input  wire wake_src_type     wake,
	// Operating-system requests
	input  wire os_req_type       osReq,
	// Configuration levels
	input  wire logic             wakeS5Enable,
	input  wire logic             restoreLastState,
	input  wire logic             lastStateOn,
	// Power status
	output logic                  powerStatus
);

	// Registered controller state and its next value
	ctrl_type        cur;
	ctrl_type        next_cur;

	// Switch filter decode
	logic            rawDiffers;
	logic            debounceDone;
	logic            releaseEvt;

	// Press classification
	logic            longEvt;
	logic            shortEvt;

	// Wake and operating-system decode
	logic            lanPme;
	logic            wakeHit;
	logic            osAccept;
	logic            restoreOn;

	// Chosen next system state
	power_state_type shortTarget;
	power_state_type next_state;

	// Raw switch level differs from the filtered one
	assign rawDiffers   = pwrSwitch != cur.swLevel;

	// New level accepted only after the whole debounce window
	assign debounceDone = rawDiffers && (cur.swCnt == DEBOUNCE_CYCLES - CNT_W'(1));

	// Filtered switch about to drop: end of a press
	assign releaseEvt   = debounceDone && cur.swLevel;

	// Fires once, on the held cycle that reaches the limit
	// Exact limit counts as long, so release on that cycle is long too
	assign longEvt      = cur.swLevel && !cur.longDone &&
		(cur.holdCnt == LONG_PRESS_CYCLES - CNT_W'(1)); // [R2] [R11]

	// Release of a press that never reached the limit
	assign shortEvt     = releaseEvt && !cur.longDone && !longEvt; // [R1]

	// Network and bus event wakes share one gate
	assign lanPme       = wake.lan || wake.pme;

	// Only a working system can be ordered to sleep or off
	assign osAccept     = osReq.valid && (cur.status.state == WORKING) &&
		(osReq.target inside {SLEEP_S1, SLEEP_S3, SLEEP_S4, SOFT_OFF}); // [R4]

	// Power-return policy from the configuration levels
	assign restoreOn    = restoreLastState && lastStateOn; // [R10]

	// Next-state logic for the whole controller
	always_comb begin
		next_cur    = cur;
		wakeHit     = 1'b0;
		shortTarget = cur.status.state;
		next_state  = cur.status.state;

		// Debounce: a level must hold for the full window to be taken
		if (!rawDiffers) begin
			next_cur.swCnt = '0;
		end else if (debounceDone) begin
			next_cur.swCnt   = '0;
			next_cur.swLevel = pwrSwitch; // [R11]
		end else begin
			next_cur.swCnt = cur.swCnt + CNT_W'(1);
		end

		// Hold timer stops at the limit so it cannot wrap
		if (!cur.swLevel) begin
			next_cur.holdCnt  = '0;
			next_cur.longDone = 1'b0;
		end else if (longEvt) begin
			next_cur.longDone = 1'b1; // [R11]
		end else if (!cur.longDone) begin
			next_cur.holdCnt = cur.holdCnt + CNT_W'(1);
		end

		// Per-state short-press target and permitted wake sources
		case (cur.status.state)
			WORKING: begin
				shortTarget = SHORT_PRESS_SLEEP; // [R3]
				wakeHit     = 1'b0;
			end
			SLEEP_S1: begin
				shortTarget = WORKING;
				wakeHit     = lanPme || wake.pcieWake || wake.ps2; // [R6] [R8]
			end
			SLEEP_S3: begin
				shortTarget = WORKING;
				wakeHit     = lanPme || wake.pcieWake || wake.ps2 || wake.rtc ||
					wake.serial || wake.usb; // [R6] [R8]
			end
			SLEEP_S4: begin
				shortTarget = WORKING;
				wakeHit     = lanPme || wake.pcieWake || wake.rtc; // [R6] [R8]
			end
			SOFT_OFF: begin
				shortTarget = WORKING;
				wakeHit     = (cur.s5WakeEn && lanPme) || wake.pcieWake ||
					wake.rtc; // [R7] [R8]
			end
			default: begin
				// Illegal code: a press falls back to the safe off state
				shortTarget = SOFT_OFF;
				wakeHit     = 1'b0;
			end
		endcase

		// Priority: power return, long press, short press, wake, OS
		if (!cur.ready) begin
			next_state = restoreOn ? WORKING : SOFT_OFF; // [R10]
		end else if (longEvt) begin
			next_state = SOFT_OFF; // [R2]
		end else if (shortEvt) begin
			next_state = shortTarget; // [R1] [R3]
		end else if (wakeHit) begin
			// Only one working state, so this is the state held before sleep
			next_state = WORKING; // [R9]
		end else if (osAccept) begin
			next_state = osReq.target; // [R4]
		end

		// Enable copied each cycle; reset leaves it off
		next_cur.s5WakeEn = wakeS5Enable; // [R7]
		next_cur.ready    = 1'b1;

		// Rails: only S0 and S1 keep main power, only S0 runs the processor
		next_cur.status.state        = next_state;
		next_cur.status.mainPowerOn  = (next_state == WORKING) ||
			(next_state == SLEEP_S1); // [R5]
		next_cur.status.cpuRunning   = next_state == WORKING; // [R5]
		next_cur.status.wakeLogicOn  = 1'b1; // [R5]
		next_cur.status.stateChanged = next_state != cur.status.state;
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cur <= CTRL_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// Output straight from the state register
	assign powerStatus = cur.status.mainPowerOn;

	// Short press from off powers up
	property p_short_from_off;
		@(posedge sys_clk) disable iff (reset)
		cur.ready && shortEvt && (cur.status.state == SOFT_OFF)
		|=> cur.status.state == WORKING;
	endproperty
	a_short_from_off: assert property (p_short_from_off) // [R1]
		else $error("short press from off did not power up");

	// Short press while working picks the sleep state
	property p_short_from_work;
		@(posedge sys_clk) disable iff (reset)
		cur.ready && shortEvt && (cur.status.state == WORKING)
		|=> cur.status.state == SHORT_PRESS_SLEEP;
	endproperty
	a_short_from_work: assert property (p_short_from_work) // [R3]
		else $error("short press while working did not sleep");

	// Long press always ends in soft-off
	property p_long_press;
		@(posedge sys_clk) disable iff (reset)
		cur.ready && longEvt
		|=> cur.status.state == SOFT_OFF;
	endproperty
	a_long_press: assert property (p_long_press) // [R2]
		else $error("long press did not force soft-off");

	// Deep sleep and off keep only the wake logic powered
	property p_deep_power;
		@(posedge sys_clk) disable iff (reset)
		(cur.status.state inside {SLEEP_S3, SLEEP_S4, SOFT_OFF})
		|-> !cur.status.mainPowerOn && !cur.status.cpuRunning &&
			cur.status.wakeLogicOn;
	endproperty
	a_deep_power: assert property (p_deep_power) // [R5]
		else $error("rail left on in deep sleep or off");

	// Network wake from off blocked while the enable is clear
	property p_s5_gate;
		@(posedge sys_clk) disable iff (reset)
		cur.ready && (cur.status.state == SOFT_OFF) && !cur.s5WakeEn &&
			!shortEvt && !wake.pcieWake && !wake.rtc
		|=> cur.status.state == SOFT_OFF;
	endproperty
	a_s5_gate: assert property (p_s5_gate) // [R7]
		else $error("off state left without a permitted source");

	// Any source wakes S3 back to working
	property p_wake_s3;
		@(posedge sys_clk) disable iff (reset)
		cur.ready && (cur.status.state == SLEEP_S3) && !longEvt &&
			(wake != '0)
		|=> cur.status.state == WORKING;
	endproperty
	a_wake_s3: assert property (p_wake_s3) // [R9]
		else $error("wake from S3 did not restore working");

	// Working state kept unless the switch or the OS says otherwise
	property p_os_only;
		@(posedge sys_clk) disable iff (reset)
		cur.ready && (cur.status.state == WORKING) && !shortEvt &&
			!longEvt && !osReq.valid
		|=> cur.status.state == WORKING;
	endproperty
	a_os_only: assert property (p_os_only) // [R4]
		else $error("working state left without a request");

	// PS/2 alone cannot wake S4
	property p_ps2_gate;
		@(posedge sys_clk) disable iff (reset)
		cur.ready && (cur.status.state == SLEEP_S4) && !shortEvt &&
			!longEvt && (wake == wake_src_type'(7'h08))
		|=> cur.status.state == SLEEP_S4;
	endproperty
	a_ps2_gate: assert property (p_ps2_gate) // [R8]
		else $error("PS/2 event woke S4");

	// Opening a S1 gate via LAN
	property p_lan_s1;
		@(posedge sys_clk) disable iff (reset)
		cur.ready && (cur.status.state == SLEEP_S1) && !longEvt && wake.lan
		|=> cur.status.state == WORKING;
	endproperty
	a_lan_s1: assert property (p_lan_s1) // [R6]
		else $error("LAN event did not wake S1");

endmodule

// ### verif/power_partner.sv
`timescale 1ns/1ps
module power_partner (
	input  wire logic sys_clk,
	output logic      pwrSwitch
);
	// Switch held n cycles, then a long idle so debounce settles
	task automatic press(input int n);
		pwrSwitch <= 1'b1;
		repeat (n) @(posedge sys_clk);
		pwrSwitch <= 1'b0;
		repeat (40) @(posedge sys_clk);
	endtask
	initial pwrSwitch = 1'b0;
endmodule

// ### verif/system_power_wake_control_tb_top.sv
`timescale 1ns/1ps
module system_power_wake_control_tb_top;
	import power_wake_pkg::*;
	logic sys_clk, reset, pwrSwitch, powerStatus;
	logic wakeS5En, restoreLast, lastOn;
	wake_src_type wake;
	os_req_type   osReq;
	int error_cnt, compares, cyc;
	power_partner sw (.sys_clk(sys_clk), .pwrSwitch(pwrSwitch));
	// Short counts keep the run brief
	system_power_wake_control #(.LONG_PRESS_CYCLES(32'h0000_0040),
		.DEBOUNCE_CYCLES(32'h0000_0004)) dut (.sys_clk(sys_clk), .reset(reset),
		.pwrSwitch(pwrSwitch), .wake(wake), .osReq(osReq), .wakeS5Enable(wakeS5En),
		.restoreLastState(restoreLast), .lastStateOn(lastOn), .powerStatus(powerStatus));
	task check(input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task results;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Wake level held long enough to be seen
	task pulse(input wake_src_type w);
		wake <= w;
		repeat (4) @(posedge sys_clk);
		wake <= '0;
		repeat (4) @(posedge sys_clk);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Hang guard
	always @(posedge sys_clk) if (++cyc > 5000) begin
		error_cnt++;
		results();
	end
	initial begin
		reset = 1'b1; wake = '0; osReq = '{1'b0, WORKING};
		wakeS5En = 1'b0; restoreLast = 1'b0; lastOn = 1'b0;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		sw.press(8);
		check(powerStatus, 1'b1);
		sw.press(72);
		check(powerStatus, 1'b0);
		pulse(7'h40);
		check(powerStatus, 1'b0);
		sw.press(8);
		osReq <= '{1'b1, SLEEP_S3};
		@(posedge sys_clk) osReq <= '{1'b0, SLEEP_S3};
		repeat (4) @(posedge sys_clk);
		check(powerStatus, 1'b0);
		pulse(7'h01);
		check(powerStatus, 1'b1);
		osReq <= '{1'b1, SOFT_OFF};
		@(posedge sys_clk) osReq <= '{1'b0, SOFT_OFF};
		repeat (4) @(posedge sys_clk);
		check(powerStatus, 1'b0);
		wakeS5En <= 1'b1;
		repeat (2) @(posedge sys_clk);
		pulse(7'h40);
		check(powerStatus, 1'b1);
		restoreLast <= 1'b1;
		lastOn <= 1'b1;
		reset <= 1'b1;
		repeat (10) @(posedge sys_clk);
		check(powerStatus, 1'b0);
		reset <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check(powerStatus, 1'b1);
		results();
	end
endmodule
